// ---- common/pms_cfg.svh ----
/*
 Timing counts and field constants for the phase and mode selector.
 Assumes a 100 MHz system clock; included by its bare name.
*/
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH
`define PMS_CLK_MHZ 100
`define PMS_MASK_US 130
`define PMS_MASK_CYC (`PMS_MASK_US * `PMS_CLK_MHZ)
`define PMS_AXI_OKAY 2'h0
`define PMS_AXI_SLVERR 2'h2
`define PMS_ADDR_CTRL 8'h00
`define PMS_ADDR_STAT 8'h04
`define PMS_ADDR_DIV 8'h08
`define PMS_ADDR_RAMP 8'h0C
`define PMS_CTRL_RST 32'h0000_0000
`define PMS_DIV_RST 16'h0064
`define PMS_RAMP_RST 16'h0032
`define PMS_VID_RST 7'h00
`define PMS_VID_LSB 0
`define PMS_VID_MSB 6
`define PMS_DIVSEL_LSB 0
`define PMS_DIVSEL_MSB 15
`define PMS_SYNC_DEPTH 3
`endif

// ---- common/pms_pkg.sv ----
/*
 Types shared by the phase and mode selector.
 Assumes pms_cfg.svh supplies the numeric constants.
*/
package pms_pkg;
    typedef enum logic [1:0] {
        PMS_PWM_CCM = 2'h0,
        PMS_RPM_CCM = 2'h1,
        PMS_RPM_AUTO = 2'h2
    } pms_mode_t;
    typedef enum logic [1:0] {
        PMS_RIP_IDLE = 2'h0,
        PMS_RIP_HIGH = 2'h1
    } pms_rip_t;
endpackage

// ---- dv/phase_mode_selector_test.sv ----
/*
 Self-checking bench for the phase and mode selector.
 Assumes pms_stage stands in for the power stage.
*/
`include "pms_cfg.svh"
module phase_mode_selector_test import pms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MASK = 400;
    logic sys_clk, rst_n, strap, lite_n, slp, lim, slow, force1;
    logic [6:0] vid;
    logic rip, rmp, zc, pe1, pe2, okr, hs1, hs2, lso, rs, dual, trans, good;
    logic [1:0] mode, bresp, rresp, r;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [3:0] tbl [7] = '{4'h4, 4'h0, 4'h1, 4'h2, 4'h7, 4'hC, 4'h4};
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 42;
    int i, k, pa, pb, pd;
    pms_top #(.MASK_CYC(MASK)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .phase_count_strap(strap),
        .light_load_indicator_n(lite_n), .deeper_sleep_request(slp),
        .vid_code(vid), .current_limit(lim), .ripple_threshold_pin(rip),
        .ramp_reached(rmp), .zero_current(zc), .pwm_end_one(pe1),
        .pwm_end_two(pe2), .output_ok_raw(okr),
        .high_side_drive_one(hs1), .high_side_drive_two(hs2),
        .low_side_off(lso), .ramp_start(rs), .dual_phase(dual),
        .op_mode(mode), .vid_transient(trans), .output_in_range(good),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    pms_stage u_stage (
        .sys_clk(sys_clk), .slow(slow), .high_side_drive_one(hs1),
        .high_side_drive_two(hs2), .ripple_threshold_pin(rip),
        .ramp_reached(rmp), .zero_current(zc), .pwm_end_one(pe1),
        .pwm_end_two(pe2), .output_ok_raw(okr));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [2:0] sel(input logic st, ln, sl, tr, cl);
        if (tr || (ln && !sl)) return {~st, PMS_PWM_CCM};
        if (cl) return {1'b0, PMS_PWM_CCM};
        if (sl) return {1'b0, PMS_RPM_AUTO};
        return {1'b0, PMS_RPM_CCM};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        output logic [1:0] rp);
        logic aw, w, b;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            #1;
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            rp = bresp;
            @(posedge sys_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end while (!b);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
        output logic [1:0] rp);
        logic ar, b;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            #1;
            ar = arvalid && arready;
            b = rvalid && rready;
            v = rdata;
            rp = rresp;
            @(posedge sys_clk);
            if (ar) arvalid <= 1'b0;
            if (b) rready <= 1'b0;
        end while (!b);
    endtask
    // Waits out any mask, then compares phases and mode with the table
    task automatic settle(input string n);
        logic [2:0] e;
        // Let pin changes clear the synchroniser before judging
        repeat (8) @(negedge sys_clk);
        e = sel(strap | force1, lite_n, slp, 1'b0, lim);
        for (i = 0; i < 2000 && (trans !== 1'b0 || {dual, mode} !== e); i++)
            @(negedge sys_clk);
        chk(n, {dual, mode}, e);
        chk("output good", good, 1'b1);
        rd(`PMS_ADDR_STAT, d, r);
        chk("status", d[10:0], {vid, 1'b0, e[1:0], e[2]});
    endtask
    // Period of phase one in cycles, rise to rise
    task automatic period(output int p);
        for (k = 0; k < 2; k++) begin
            p = 0;
            while (hs1 !== 1'b0 && p < 9000) begin
                @(negedge sys_clk);
                p++;
            end
            while (hs1 !== 1'b1 && p < 9000) begin
                @(negedge sys_clk);
                p++;
            end
        end
    endtask
    initial begin
        rst_n = 1'b0;
        {strap, slp, lim, slow, force1, awvalid, wvalid, bready} = '0;
        {arvalid, rready, awaddr, araddr, wdata} = '0;
        lite_n = 1'b1;
        vid = 7'h55;
        wstrb = 4'hF;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`PMS_ADDR_DIV, d, r);
        chk("div resp", r, `PMS_AXI_OKAY);
        chk("div reset", d, {16'h0, `PMS_DIV_RST});
        wr(`PMS_ADDR_RAMP, 32'h0000_012C, r);
        rd(`PMS_ADDR_RAMP, d, r);
        chk("slow resp", r, `PMS_AXI_OKAY);
        chk("slow div", d, 32'h0000_012C);
        wr(8'h10, 32'h0000_0001, r);
        chk("unmapped wr", r, `PMS_AXI_SLVERR);
        rd(8'h10, d, r);
        chk("unmapped resp", r, `PMS_AXI_SLVERR);
        chk("unmapped rd", d, 32'h0);
        wstrb <= 4'h0;
        wr(`PMS_ADDR_CTRL, 32'h0000_0001, r);
        chk("no strobe resp", r, `PMS_AXI_OKAY);
        rd(`PMS_ADDR_CTRL, d, r);
        chk("no strobe", d, 32'h0);
        wstrb <= 4'hF;
        settle("after reset");
        $display("done registers");
        for (int s = 0; s < 7; s++) begin
            @(posedge sys_clk);
            {strap, lite_n, slp, lim} <= tbl[s];
            d = 32'($random(seed));
            vid <= d[6:0] == vid ? ~vid : d[6:0];
            slow <= d[8];
            for (i = 0; i < 200 && {trans, mode} !== 3'h4; i++)
                @(negedge sys_clk);
            chk("mask mode", {trans, mode}, {1'b1, PMS_PWM_CCM});
            settle("steady");
            $display("done step %0d", s);
        end
        wr(`PMS_ADDR_CTRL, 32'h1, r);
        @(posedge sys_clk);
        force1 <= 1'b1;
        settle("forced single");
        wr(`PMS_ADDR_CTRL, 32'h0, r);
        @(posedge sys_clk);
        force1 <= 1'b0;
        vid <= 7'h55;
        settle("dual");
        period(pd);
        pb = 0;
        while (hs2 !== 1'b1 && pb < 9000) begin
            @(negedge sys_clk);
            pb++;
        end
        chk("phase two lag", pb, 32'(`PMS_DIV_RST) + 1);
        @(posedge sys_clk);
        strap <= 1'b1;
        settle("single");
        period(pa);
        chk("phase rate", pd, 2 * pa);
        @(posedge sys_clk);
        vid <= 7'h15;
        settle("low code");
        period(pb);
        chk("code rate", pb > pa, 1);
        $display("done rates");
        close_out();
    end
endmodule

// ---- dv/pms_checker.sv ----
/*
 Port assertions for the phase and mode selector.
 Assumes binding to pms_top with a mask shorter than 990 cycles.
*/
module pms_checker
    import pms_pkg::*;
#(
    parameter int MASK_CYC = 50
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins watched
    input wire logic [6:0] vid_code,
    input wire logic deeper_sleep_request,
    input wire logic ramp_reached,
    input wire logic high_side_drive_one,
    input wire logic low_side_off,
    input wire logic ramp_start,
    input wire logic dual_phase,
    input wire logic [1:0] op_mode,
    input wire logic vid_transient,
    input wire logic output_in_range
);
    // Slack for synchroniser depth at both ends of the mask
    localparam int MLO = MASK_CYC - 4;
    localparam int MHI = MASK_CYC + 4;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence mask_opens;
        ##[1:8] vid_transient;
    endsequence
    sequence drive_sets;
        ##[0:1] high_side_drive_one;
    endsequence
    sequence ramp_hit;
        (op_mode != PMS_PWM_CCM && high_side_drive_one && ramp_reached)[*2];
    endsequence
    ramp_pulse_a: assert property (ramp_start |=> !ramp_start)
        else $error("ramp start wider than one cycle");
    ramp_sets_a: assert property (ramp_start |-> drive_sets)
        else $error("ramp start without phase one drive");
    ramp_mode_a: assert property (ramp_start |-> op_mode != PMS_PWM_CCM)
        else $error("ramp start in clocked mode");
    ramp_reset_a: assert property (ramp_hit |-> ##[0:8] !high_side_drive_one)
        else $error("phase one drive not reset at ramp end");
    dcm_mode_a: assert property (low_side_off |-> op_mode == PMS_RPM_AUTO
        || $past(op_mode) == PMS_RPM_AUTO)
        else $error("low side off outside automatic mode");
    dual_pwm_a: assert property (dual_phase |-> op_mode == PMS_PWM_CCM)
        else $error("two phases outside clocked mode");
    vid_start_a: assert property ($changed(vid_code) |-> mask_opens)
        else $error("code change did not open mask");
    sleep_start_a: assert property ($changed(deeper_sleep_request)
        |-> mask_opens)
        else $error("sleep change did not open mask");
    mask_len_a: assert property ($rose(vid_transient)
        |-> ##[MLO:MHI] $fell(vid_transient))
        else $error("mask length wrong");
    mask_good_a: assert property (vid_transient [*2] |-> !output_in_range)
        else $error("output good shown while masked");
endmodule

bind pms_top pms_checker #(.MASK_CYC(MASK_CYC)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .vid_code(vid_code),
    .deeper_sleep_request(deeper_sleep_request),
    .ramp_reached(ramp_reached), .high_side_drive_one(high_side_drive_one),
    .low_side_off(low_side_off), .ramp_start(ramp_start),
    .dual_phase(dual_phase), .op_mode(op_mode),
    .vid_transient(vid_transient), .output_in_range(output_in_range)
);

// ---- dv/pms_stage.sv ----
/*
 Behavioural power stage and comparators facing the selector.
 Assumes drives are registered levels; slow doubles every on-time.
*/
module pms_stage #(
    parameter int RIP_PER = 60,
    parameter int ON_CYC = 12
) (
    // Clock and pace
    input wire logic sys_clk,
    input wire logic slow,
    // Drives
    input wire logic high_side_drive_one,
    input wire logic high_side_drive_two,
    // Comparator levels
    output logic ripple_threshold_pin,
    output logic ramp_reached,
    output logic zero_current,
    output logic pwm_end_one,
    output logic pwm_end_two,
    output logic output_ok_raw
);
    int on1 = 0;
    int on2 = 0;
    int off1 = 0;
    int lim;
    always @(posedge sys_clk) begin
        on1 <= high_side_drive_one ? on1 + 1 : 0;
        on2 <= high_side_drive_two ? on2 + 1 : 0;
        off1 <= high_side_drive_one ? 0 : off1 + 1;
    end
    assign lim = slow ? 2 * ON_CYC : ON_CYC;
    // Crossing held six cycles so the input filter sees it
    assign ripple_threshold_pin = !high_side_drive_one
        && (off1 % RIP_PER) >= RIP_PER - 6;
    // Levels stay up until the drive drops, as a real comparator would
    assign ramp_reached = on1 >= lim;
    assign pwm_end_one = on1 >= lim;
    assign pwm_end_two = on2 >= lim;
    assign zero_current = off1 >= RIP_PER / 2;
    assign output_ok_raw = 1'b1;
endmodule

// ---- src/pms_sync.sv ----
/*
 Three-stage input synchroniser with agreement filter.
 Assumes asynchronous inputs; output changes once stages two and three agree.
*/
`include "pms_cfg.svh"
module pms_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_b
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    q_ff[i] <= 1'b0;
                end else if (s2_ff[i] == s3_ff[i]) begin
                    q_ff[i] <= s3_ff[i];
                end
            end
        end
    endgenerate
    assign dout = q_ff;
endmodule

// ---- src/pms_top.sv ----
/*
 Phase-count and control-method selector for a two-phase buck controller,
 with an AXI4-Lite register slave.
 Assumes analog comparators arrive as asynchronous digital levels, and that
 the power stage honours the drive and low-side-off outputs.
*/
`include "pms_cfg.svh"
module pms_top
    import pms_pkg::*;
#(
    parameter int MASK_CYC = `PMS_MASK_CYC,
    parameter int DIV_W = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins from CPU and board
    input wire logic phase_count_strap,
    input wire logic light_load_indicator_n,
    input wire logic deeper_sleep_request,
    input wire logic [6:0] vid_code,
    // Analog comparator levels
    input wire logic current_limit,
    input wire logic ripple_threshold_pin,
    input wire logic ramp_reached,
    input wire logic zero_current,
    input wire logic pwm_end_one,
    input wire logic pwm_end_two,
    input wire logic output_ok_raw,
    // Power stage drive
    output logic high_side_drive_one,
    output logic high_side_drive_two,
    output logic low_side_off,
    output logic ramp_start,
    output logic dual_phase,
    output logic [1:0] op_mode,
    output logic vid_transient,
    output logic output_in_range,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int NS = 17;
    logic [NS-1:0] sy;
    logic strap_s, lli_n_s, dslp_s, ilim_s, rip_s, rmp_s, zc_s;
    logic pe1_s, pe2_s, ok_s;
    logic [6:0] vid_s;
    pms_sync #(.W(NS)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .din({phase_count_strap, light_load_indicator_n,
              deeper_sleep_request, current_limit, ripple_threshold_pin,
              ramp_reached, zero_current, pwm_end_one, pwm_end_two,
              output_ok_raw, vid_code}),
        .dout(sy)
    );
    assign {strap_s, lli_n_s, dslp_s, ilim_s, rip_s, rmp_s, zc_s,
            pe1_s, pe2_s, ok_s, vid_s} = sy;

    // Software registers
    logic [DIV_W-1:0] div_hi_ff;
    logic [DIV_W-1:0] div_lo_ff;
    logic [31:0] ctrl_ff;
    logic force_single;
    assign force_single = ctrl_ff[0];

    // Transient detection and power-good mask
    logic [6:0] vid_prev_ff;
    logic dslp_prev_ff;
    logic [31:0] mask_cnt_ff;
    logic change;
    assign change = (vid_s != vid_prev_ff) || (dslp_s != dslp_prev_ff);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vid_prev_ff <= `PMS_VID_RST;
            dslp_prev_ff <= 1'b0;
        end else begin
            vid_prev_ff <= vid_s;
            dslp_prev_ff <= dslp_s;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_cnt_ff <= '0;
        end else if (change) begin
            mask_cnt_ff <= 32'(MASK_CYC);
        end else if (mask_cnt_ff != '0) begin
            mask_cnt_ff <= mask_cnt_ff - 32'h1;
        end
    end
    logic trans;
    assign trans = (mask_cnt_ff != '0) || change;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_in_range <= 1'b0;
            vid_transient <= 1'b0;
        end else begin
            output_in_range <= ok_s && !trans;
            vid_transient <= trans;
        end
    end

    // Selection table
    logic nxt_dual;
    pms_mode_t nxt_mode;
    always_comb begin
        nxt_dual = 1'b0;
        nxt_mode = PMS_PWM_CCM;
        if (trans) begin
            nxt_dual = !strap_s && !force_single;
        end else if (lli_n_s && !dslp_s) begin
            nxt_dual = !strap_s && !force_single;
        end else if (ilim_s) begin
            nxt_mode = PMS_PWM_CCM;
        end else if (dslp_s) begin
            nxt_mode = PMS_RPM_AUTO;
        end else begin
            nxt_mode = PMS_RPM_CCM;
        end
        if (strap_s) begin
            nxt_dual = 1'b0;
        end
    end

    // Master clock and phase counter
    logic [DIV_W-1:0] clk_cnt_ff;
    logic phase_sel_ff;
    logic tick;
    logic [DIV_W-1:0] div_now;
    assign div_now = vid_s[`PMS_VID_MSB] ? div_hi_ff : div_lo_ff;
    assign tick = (clk_cnt_ff >= div_now);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_cnt_ff <= '0;
        end else if (tick) begin
            clk_cnt_ff <= '0;
        end else begin
            clk_cnt_ff <= clk_cnt_ff + 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_sel_ff <= 1'b0;
        end else if (tick) begin
            phase_sel_ff <= dual_phase ? !phase_sel_ff : 1'b0;
        end
    end

    // Applied mode, updated only at cycle boundaries
    pms_mode_t mode_ff;
    logic dual_ff;
    logic boundary;
    logic rip_edge;
    pms_rip_t rip_st_ff;
    // No mode switch in the cycle a new ripple cycle starts
    assign boundary = (mode_ff == PMS_PWM_CCM) ? tick
                    : (rip_st_ff == PMS_RIP_IDLE) && !rip_edge;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= PMS_PWM_CCM;
            dual_ff <= 1'b0;
        end else if (boundary) begin
            mode_ff <= nxt_mode;
            dual_ff <= nxt_dual;
        end
    end
    assign dual_phase = dual_ff;
    assign op_mode = mode_ff;

    // Drives; each phase ends on its own modulator output
    logic hs1_ff, hs2_ff, lso_ff, rs_ff;
    logic rip_prev_ff;
    assign rip_edge = rip_s && !rip_prev_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rip_prev_ff <= 1'b0;
        end else begin
            rip_prev_ff <= rip_s;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rip_st_ff <= PMS_RIP_IDLE;
        end else if (mode_ff == PMS_PWM_CCM) begin
            rip_st_ff <= PMS_RIP_IDLE;
        end else begin
            unique case (rip_st_ff)
                PMS_RIP_IDLE: begin
                    if (rip_s && !rip_prev_ff) begin
                        rip_st_ff <= PMS_RIP_HIGH;
                    end
                end
                PMS_RIP_HIGH: begin
                    if (rmp_s) begin
                        rip_st_ff <= PMS_RIP_IDLE;
                    end
                end
                default: rip_st_ff <= PMS_RIP_IDLE;
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs1_ff <= 1'b0;
        end else if (mode_ff != PMS_PWM_CCM) begin
            hs1_ff <= (rip_st_ff == PMS_RIP_IDLE) ? (rip_s && !rip_prev_ff)
                    : !rmp_s;
        end else if (tick && !phase_sel_ff) begin
            hs1_ff <= 1'b1;
        end else if (pe1_s) begin
            hs1_ff <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs2_ff <= 1'b0;
        end else if (!dual_ff || mode_ff != PMS_PWM_CCM) begin
            hs2_ff <= 1'b0;
        end else if (tick && phase_sel_ff) begin
            hs2_ff <= 1'b1;
        end else if (pe2_s) begin
            hs2_ff <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lso_ff <= 1'b0;
            rs_ff <= 1'b0;
        end else begin
            // Low side only released in auto mode while high side is off
            lso_ff <= (mode_ff == PMS_RPM_AUTO) && zc_s && !hs1_ff;
            rs_ff <= (mode_ff != PMS_PWM_CCM) && (rip_st_ff == PMS_RIP_IDLE)
                  && rip_s && !rip_prev_ff;
        end
    end
    assign high_side_drive_one = hs1_ff;
    assign high_side_drive_two = hs2_ff;
    assign low_side_off = lso_ff;
    assign ramp_start = rs_ff;

    // AXI4-Lite write path; address and data taken in either order
    logic aw_ok_ff, w_ok_ff, bv_ff;
    logic ws_ff;
    logic [7:0] aw_ff;
    logic [31:0] wd_ff;
    logic [1:0] br_ff;
    assign s_axi_awready = !aw_ok_ff && !bv_ff;
    assign s_axi_wready = !w_ok_ff && !bv_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            aw_ff <= '0;
            wd_ff <= '0;
            ws_ff <= 1'b0;
        end else if (aw_ok_ff && w_ok_ff) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_ff <= 1'b1;
                aw_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_ff <= 1'b1;
                wd_ff <= s_axi_wdata;
                // Strobes are only valid with the data beat
                ws_ff <= (s_axi_wstrb != 4'h0);
            end
        end
    end
    logic wr_go;
    assign wr_go = aw_ok_ff && w_ok_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= `PMS_CTRL_RST;
            div_hi_ff <= DIV_W'(`PMS_DIV_RST);
            div_lo_ff <= DIV_W'(`PMS_DIV_RST) + DIV_W'(`PMS_DIV_RST);
        end else if (wr_go && ws_ff) begin
            if (aw_ff == `PMS_ADDR_CTRL) begin
                ctrl_ff <= {31'h0, wd_ff[0]};
            end
            if (aw_ff == `PMS_ADDR_DIV) begin
                div_hi_ff <= wd_ff[`PMS_DIVSEL_MSB:`PMS_DIVSEL_LSB];
            end
            if (aw_ff == `PMS_ADDR_RAMP) begin
                div_lo_ff <= wd_ff[`PMS_DIVSEL_MSB:`PMS_DIVSEL_LSB];
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bv_ff <= 1'b0;
            br_ff <= `PMS_AXI_OKAY;
        end else if (wr_go) begin
            bv_ff <= 1'b1;
            br_ff <= (aw_ff == `PMS_ADDR_CTRL || aw_ff == `PMS_ADDR_DIV
                   || aw_ff == `PMS_ADDR_RAMP) ? `PMS_AXI_OKAY
                   : `PMS_AXI_SLVERR;
        end else if (s_axi_bready) begin
            bv_ff <= 1'b0;
        end
    end
    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = br_ff;

    // AXI4-Lite read path
    logic rv_ff;
    logic [31:0] rd_ff;
    logic [1:0] rr_ff;
    assign s_axi_arready = !rv_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rv_ff <= 1'b0;
            rd_ff <= '0;
            rr_ff <= `PMS_AXI_OKAY;
        end else if (s_axi_arvalid && !rv_ff) begin
            rv_ff <= 1'b1;
            rr_ff <= `PMS_AXI_OKAY;
            unique case (s_axi_araddr)
                `PMS_ADDR_CTRL: rd_ff <= ctrl_ff;
                `PMS_ADDR_STAT: rd_ff <= {21'h0, vid_s, trans, mode_ff,
                                          dual_ff};
                `PMS_ADDR_DIV: rd_ff <= 32'(div_hi_ff);
                `PMS_ADDR_RAMP: rd_ff <= 32'(div_lo_ff);
                default: begin
                    rd_ff <= '0;
                    rr_ff <= `PMS_AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rv_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rdata = rd_ff;
    assign s_axi_rresp = rr_ff;
endmodule
